// File: hdl/tss_map.vh
`ifndef TSS_MAP_VH
`define TSS_MAP_VH

// Serial frame layout
`define TSS_TX_BITS        6'd16
`define TSS_ACCESS_BITS    6'd32
`define TSS_RX_BITS        4'd8
`define TSS_TEMP_BITS      14

// Mode codes captured in the receive phase
`define TSS_CODE_CONT      8'h00
`define TSS_CODE_SHUTDOWN  8'hff

// Transmitted words; identity value is arbitrary, low two bits stay ones
`define TSS_ID_WORD        16'h5a53
`define TSS_INVALID_WORD   16'h0003
`define TSS_PAD_BITS       2'b11

// Reset values
`define TSS_RST_SHUTDOWN   1'b0
`define TSS_RST_WORD       16'hffff

// Conversion timing
`define TSS_CONV_TIME_MS   200
`define TSS_CLK_KHZ        125000

`endif

// File: hdl/tss_sync.v
`timescale 1ns/1ps
// Three-stage input synchroniser; output follows once stages two and three agree
module tss_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire sys_clk,
    input  wire reset,
    input  wire asyncIn,
    output reg  syncOut
);
    reg stage1_q;    // Metastability catcher, read only by stage2
    reg stage2_q;    // Second stage
    reg stage3_q;    // Third stage

    // Shift chain and agreement filter
    always @(posedge sys_clk) begin
        if (reset) begin
            stage1_q <= RST_VAL;
            stage2_q <= RST_VAL;
            stage3_q <= RST_VAL;
            syncOut  <= RST_VAL;
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            // Only a settled level is passed on
            if (stage2_q == stage3_q) begin
                syncOut <= stage3_q;
            end
        end
    end
endmodule

// File: hdl/tss_fifo.v
`timescale 1ns/1ps
// Small synchronous FIFO with valid/ready on both sides
module tss_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output reg  [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];   // Storage array
    reg [AW-1:0]    wrPtr_q;           // Write index
    reg [AW-1:0]    rdPtr_q;           // Read index
    reg [AW:0]      count_q;           // Fill level

    wire doPush;
    wire doPop;

    assign inReady  = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    // Read data is the head entry, shown without a register stage
    always @* begin
        outData = mem[rdPtr_q];
    end

    // Pointers and level; wraps rely on DEPTH being a power of two
    always @(posedge sys_clk) begin
        if (reset) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                mem[wrPtr_q] <= inData;
                wrPtr_q      <= wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            if (doPush && !doPop) begin
                count_q <= count_q + 1'b1;
            end else if (doPop && !doPush) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// File: hdl/tss_top.v
`timescale 1ns/1ps
`include "tss_map.vh"

// Overview of operation
// - Reset brings continuous conversion mode up
// - Invalid word sent until first conversion done
// - Power-up reset restores default register state
// - Reads never abort a running conversion
// - After read, load latest result, restart conversion (code: read end starts no conversion; the loop restarts on its own)
// - Result load waits for chip select high
// - Drive on falling, sample on rising edge
// - Access is 16 transmit plus 16 receive
// - Data line released while chip select high
// - First bit driven as chip select falls
// - Early chip select rise ends access cleanly
// - Receive phase after 16 clocks, max 32
// - Receive bits shift into eight-bit register
// - All ones shutdown, all zeros continuous
// - Only last eight bits decide mode
// - 14-bit temperature in bits 15..2, ones below
// - Most significant bit shifted out first
// - Shutdown sends identity word, port active
module tss_top #(
    parameter CONV_CYCLES = `TSS_CONV_TIME_MS * `TSS_CLK_KHZ,
    parameter CNT_W       = 25,
    parameter FIFO_DEPTH  = 8,
    parameter FIFO_AW     = 3
) (
    input  wire                      sys_clk,
    input  wire                      reset,
    input  wire                      chipSelectN,
    input  wire                      serialClockIn,
    input  wire                      dataIn,
    output wire                      dataOut,
    output wire                      dataOe,
    input  wire [`TSS_TEMP_BITS-1:0] tempCode,
    output wire                      convActive,
    output wire                      shutdownMode
);
    // Sequencer states
    localparam CONV_IDLE = 2'd0;
    localparam CONV_RUN  = 2'd1;
    localparam CONV_PUSH = 2'd2;

    // Timing budget: each pin is seen four cycles after it moves and a
    // shifted bit reaches the pin one cycle later. A host clock period of
    // a dozen system clocks or more keeps every new bit settled before the
    // next rising edge; a faster host would read each bit one period late.
    // Glitch-free sampling from an unrelated clock was worth that limit.

    // Synchronised pins
    wire csN;                        // Chip select, active low, settled
    wire sclk;                       // Serial clock, settled
    wire sdi;                        // Incoming data, settled

    reg  csN_q;                      // Previous chip select for edges
    reg  sclk_q;                     // Previous serial clock for edges
    wire csFall;                     // Select seen going low
    wire csRise;                     // Select seen going high
    wire sclkRise;                   // Serial clock rose while selected
    wire sclkFall;                   // Serial clock fell while selected

    // Phase decode from the edge counters
    wire txPhase;                    // Still shifting the result word out
    wire rxPhase;                    // Sixteen rising edges already seen
    wire modeLoad;                   // Deselect after a whole code byte

    // Serial engine state
    reg  [15:0] txShift_q;           // Outgoing word
    reg  [5:0]  riseCnt_q;           // Rising edges since select
    reg  [5:0]  fallCnt_q;           // Falling edges since select
    reg  [7:0]  rxByte_q;            // Last eight received bits
    reg  [3:0]  rxCnt_q;             // Received bits, saturating at eight
    reg         shutdown_q;          // Mode flag
    reg         resultValid_q;       // First conversion finished
    reg  [`TSS_TEMP_BITS-1:0] result_q;  // Latest completed result

    // Conversion sequencer state
    reg  [1:0]       convState_q;
    reg  [1:0]       convState_d;
    reg  [CNT_W-1:0] convTimer_q;
    reg  [`TSS_TEMP_BITS-1:0] sample_q;  // Code captured at end of conversion
    reg              restartReq_q;       // Read finished, restart pending

    // FIFO between converter and result register
    wire                      fifoInReady;
    wire                      fifoOutValid;
    wire [`TSS_TEMP_BITS-1:0] fifoOutData;
    wire                      fifoPush;
    wire                      fifoPop;
    wire [15:0]               loadWord;

    // Pin synchronisers; chip select starts at its idle high level so
    // that reset cannot fake a select
    tss_sync #(.RST_VAL(1'b1)) uSyncCs (
        .sys_clk (sys_clk),
        .reset   (reset),
        .asyncIn (chipSelectN),
        .syncOut (csN)
    );

    tss_sync #(.RST_VAL(1'b0)) uSyncClk (
        .sys_clk (sys_clk),
        .reset   (reset),
        .asyncIn (serialClockIn),
        .syncOut (sclk)
    );

    tss_sync #(.RST_VAL(1'b0)) uSyncData (
        .sys_clk (sys_clk),
        .reset   (reset),
        .asyncIn (dataIn),
        .syncOut (sdi)
    );

    // The FIFO decouples conversions from reads: results pile up while the
    // host holds select and drain into the result register afterwards
    tss_fifo #(
        .WIDTH (`TSS_TEMP_BITS),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) uFifo (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .inData   (sample_q),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (fifoPop)
    );

    // Edge detection on settled pins
    // Reset values equal the idle pin levels, so no false edge follows reset
    always @(posedge sys_clk) begin
        if (reset) begin
            csN_q  <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            csN_q  <= csN;
            sclk_q <= sclk;
        end
    end

    assign csFall   = csN_q && !csN;
    assign csRise   = !csN_q && csN;
    assign sclkRise = !csN && !sclk_q && sclk;
    assign sclkFall = !csN && sclk_q && !sclk;

    // Transmit phase lasts until the sixteenth falling edge
    assign txPhase  = (fallCnt_q < `TSS_TX_BITS);
    // Receive phase opens once sixteen clock periods have passed
    assign rxPhase  = (riseCnt_q >= `TSS_TX_BITS);
    // A code counts only at deselect and only after a whole byte
    assign modeLoad = csRise && (rxCnt_q == `TSS_RX_BITS);

    // Word picked at select: identity in shutdown, else result with pad ones
    assign loadWord = shutdown_q ? `TSS_ID_WORD :
                      resultValid_q ? {result_q, `TSS_PAD_BITS} :
                      `TSS_INVALID_WORD;

    // Drive only while selected and still in the transmit phase; the pin is
    // released a few cycles after deselect because select is synchronised
    assign dataOe  = !csN && txPhase;
    // The top bit of the shifter stands on the pin, most significant first
    assign dataOut = txShift_q[15];

    // Serial shift engine and phase counters
    always @(posedge sys_clk) begin
        if (reset) begin
            txShift_q <= `TSS_RST_WORD;
            riseCnt_q <= 6'd0;
            fallCnt_q <= 6'd0;
            rxByte_q  <= 8'h00;
            rxCnt_q   <= 4'd0;
        end else if (csN) begin
            // Deselected: counters cleared, so a truncated access leaves no trace
            riseCnt_q <= 6'd0;
            fallCnt_q <= 6'd0;
            rxCnt_q   <= 4'd0;
            // The word follows mode and result every cycle, so the first
            // bit already stands when select is seen
            txShift_q <= loadWord;
        end else begin
            if (csFall) begin
                // Hold the preloaded word rather than reload it: a result
                // popped on the last deselected cycle must not swap the word
                // under a pin that is already driven
                txShift_q <= txShift_q;
            end else if (sclkFall && fallCnt_q < `TSS_ACCESS_BITS) begin
                txShift_q <= {txShift_q[14:0], 1'b1};
                fallCnt_q <= fallCnt_q + 6'd1;
            end
            if (sclkRise && riseCnt_q < `TSS_ACCESS_BITS) begin
                riseCnt_q <= riseCnt_q + 6'd1;
                // Receive phase starts after sixteen periods
                if (rxPhase) begin
                    rxByte_q <= {rxByte_q[6:0], sdi};
                    // Saturating: only whether a whole byte came in matters
                    if (rxCnt_q < `TSS_RX_BITS) begin
                        rxCnt_q <= rxCnt_q + 4'd1;
                    end
                end
            end
        end
    end

    // Mode update at end of access; partial bytes are ignored
    always @(posedge sys_clk) begin
        if (reset) begin
            shutdown_q <= `TSS_RST_SHUTDOWN;
        end else if (modeLoad) begin
            // Any other byte leaves the mode alone, so an undefined code
            // cannot push the block into a state nobody can name
            if (rxByte_q == `TSS_CODE_SHUTDOWN) begin
                shutdown_q <= 1'b1;
            end else if (rxByte_q == `TSS_CODE_CONT) begin
                shutdown_q <= 1'b0;
            end
        end
    end

    assign shutdownMode = shutdown_q;

    // Result register: filled from the FIFO only while deselected.
    // The FIFO hands out its oldest code first; a few deselected cycles
    // drain it, so the newest code is the one that stays.
    assign fifoPop = fifoOutValid && csN && !csRise;
    always @(posedge sys_clk) begin
        if (reset) begin
            result_q      <= {`TSS_TEMP_BITS{1'b0}};
            resultValid_q <= 1'b0;
        end else if (fifoPop) begin
            result_q      <= fifoOutData;
            resultValid_q <= 1'b1;
        end
    end

    // A finished read asks for a fresh conversion once idle
    always @(posedge sys_clk) begin
        if (reset) begin
            restartReq_q <= 1'b0;
        end else if (csRise) begin
            restartReq_q <= 1'b1;
        end else if (convState_q == CONV_IDLE) begin
            restartReq_q <= 1'b0;
        end
    end

    // Conversion sequencer next state; reads do not touch a running one
    always @* begin
        convState_d = convState_q;
        case (convState_q)
            CONV_IDLE: begin
                // Shutdown suspends new conversions. In continuous mode the
                // loop restarts on its own, so the read-end request adds no
                // extra start there and can never wake a sleeping converter
                if (!shutdown_q || (restartReq_q && !shutdown_q)) begin
                    convState_d = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (convTimer_q == CONV_CYCLES[CNT_W-1:0] - 1'b1) begin
                    convState_d = CONV_PUSH;
                end
            end
            CONV_PUSH: begin
                // A full FIFO stalls the converter here. A host that keeps
                // select low for many conversions thus freezes the newest
                // code at the ninth result, until it deselects.
                if (fifoInReady) begin
                    convState_d = CONV_IDLE;
                end
            end
            default: begin
                convState_d = CONV_IDLE;
            end
        endcase
    end

    assign fifoPush   = (convState_q == CONV_PUSH);
    assign convActive = (convState_q == CONV_RUN);

    // Sequencer registers and conversion timer
    always @(posedge sys_clk) begin
        if (reset) begin
            convState_q <= CONV_IDLE;
            convTimer_q <= {CNT_W{1'b0}};
            sample_q    <= {`TSS_TEMP_BITS{1'b0}};
        end else begin
            convState_q <= convState_d;
            if (convState_q == CONV_RUN) begin
                convTimer_q <= convTimer_q + 1'b1;
                if (convState_d == CONV_PUSH) begin
                    // Code taken in the last cycle of the conversion
                    sample_q <= tempCode;
                end
            end else begin
                convTimer_q <= {CNT_W{1'b0}};
            end
        end
    end
endmodule

// File: tb/tss_top_assertions.sv
`timescale 1ns/1ps
`include "tss_map.vh"
// Watches the top ports; sync delays allow up to six cycles
module tss_top_assertions (
    input wire                      sys_clk,
    input wire                      reset,
    input wire                      chipSelectN,
    input wire                      serialClockIn,
    input wire                      dataIn,
    input wire                      dataOut,
    input wire                      dataOe,
    input wire [`TSS_TEMP_BITS-1:0] tempCode,
    input wire                      convActive,
    input wire                      shutdownMode
);
    reg       sckPrev_q; // Serial clock one cycle back
    reg [5:0] fallCnt_q; // Raw falling edges seen while selected
    // Counter cleared when deselected, so a short access cannot leak
    always @(posedge sys_clk) begin
        sckPrev_q <= serialClockIn;
        if (reset || chipSelectN) begin
            fallCnt_q <= 6'h00;
        end else if (sckPrev_q && !serialClockIn) begin
            fallCnt_q <= fallCnt_q + 6'h01;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_sel_fall; $fell(chipSelectN); endsequence
    sequence s_oe_soon; ##[1:6] dataOe; endsequence
    sequence s_idle; chipSelectN [*6]; endsequence
    a_first_bit_out: assert property (s_sel_fall |-> s_oe_soon)
        else $error("data line not driven after select");
    a_idle_float: assert property (s_idle |-> !dataOe)
        else $error("data line driven while deselected");
    a_oe_has_sel: assert property ($rose(dataOe) |-> !$past(chipSelectN, 3))
        else $error("data line driven without select");
    a_early_end: assert property ($rose(chipSelectN) |-> ##[1:6] !dataOe)
        else $error("data line held after early deselect");
    a_tx_sixteen: assert property (fallCnt_q > 6'h10 |-> !dataOe)
        else $error("data line driven in receive phase");
    a_fall_shift: assert property (dataOe && $past(dataOe) && $changed(dataOut)
        |-> $past(serialClockIn, 7) && !$past(serialClockIn, 3))
        else $error("output bit changed without falling edge");
    a_mode_at_end: assert property ($changed(shutdownMode)
        |-> chipSelectN && $past(chipSelectN, 3))
        else $error("mode changed while selected");
    a_sleep_halts: assert property (shutdownMode && !convActive |=> !convActive)
        else $error("conversion started in shutdown");
    a_boot_cont: assert property ($fell(reset) |-> ##[0:3] convActive && !shutdownMode)
        else $error("no continuous conversion after reset");
endmodule
bind tss_top tss_top_assertions chk_u (.sys_clk(sys_clk), .reset(reset),
    .chipSelectN(chipSelectN), .serialClockIn(serialClockIn), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .tempCode(tempCode),
    .convActive(convActive), .shutdownMode(shutdownMode));

// File: tb/tss_host_model.sv
`timescale 1ns/1ps
// Serial master; clock idles low between frames
module tss_host_model (
    output reg  chipSelectN,
    output reg  serialClockIn,
    output wire dataIn,
    input  wire dataOut,
    input  wire dataOe
);
    reg  hostOe;                               // Host drives the data line
    reg  hostBit;                              // Host bit on the line
    reg  lastLvl;                              // Last driven level
    wire drv    = dataOe | hostOe;             // Anyone driving
    wire drvVal = dataOe ? dataOut : hostBit;  // Driven level
    // Released line shows the inverse, so a stale sample is caught
    always @(drv or drvVal) begin
        if (drv) begin
            lastLvl = drvVal;
        end
    end
    assign dataIn = drv ? drvVal : ~lastLvl;
    initial begin
        chipSelectN   = 1'b1;
        serialClockIn = 1'b0;
        hostOe        = 1'b0;
        hostBit       = 1'b0;
        lastLvl       = 1'b0;
    end
    // One access; odd offset keeps edges off the system clock edge
    task access(input integer nClk, input [15:0] rx, input real lead,
                output [15:0] tx);
        integer k;
        begin
            tx = 16'h0000;
            #3.3 chipSelectN = 1'b0;
            #(lead);
            for (k = 1; k <= nClk; k = k + 1) begin
                serialClockIn = 1'b1;
                if (k <= 16) begin
                    tx[16-k] = dataIn;
                end
                #62.5 serialClockIn = 1'b0;
                if (k >= 16 && k < 32) begin
                    hostOe  = 1'b1;
                    hostBit = rx[31-k];
                end
                #62.5;
            end
            chipSelectN = 1'b1;
            hostOe      = 1'b0;
            #200;
        end
    endtask
endmodule

// File: tb/tss_top_test.sv
`timescale 1ns/1ps
`include "tss_map.vh"
module tss_top_test;
    localparam CONV = 200; // Short conversion for simulation
    reg                      sys_clk;  // System clock
    reg                      reset;    // Sync reset
    reg [`TSS_TEMP_BITS-1:0] tempCode; // Converter code
    wire chipSelectN, serialClockIn, dataIn, dataOut, dataOe, convActive, shutdownMode;
    reg [15:0]               w;        // Word read back
    integer                  err_total;
    integer                  n_checks;
    tss_top #(.CONV_CYCLES(CONV)) dut_u (.sys_clk(sys_clk), .reset(reset),
        .chipSelectN(chipSelectN), .serialClockIn(serialClockIn), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .tempCode(tempCode),
        .convActive(convActive), .shutdownMode(shutdownMode));
    tss_host_model host_u (.chipSelectN(chipSelectN), .serialClockIn(serialClockIn),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
    always #4 sys_clk = ~sys_clk;
    task check(input string name, input [15:0] seen, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task test_done;
        begin
            if (err_total == 0 && n_checks > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    // Bounded wait for conversions to run again
    task wait_conv;
        integer i;
        begin
            for (i = 0; i < 300 && convActive !== 1'b1; i = i + 1) begin
                @(posedge sys_clk);
            end
            check("convActive", {15'h0000, convActive}, 16'h0001);
            if (convActive !== 1'b1) test_done;
        end
    endtask
    // Idle after reset, then read during the first conversion
    task t_first_read;
        begin
            check("shutdown", {15'h0000, shutdownMode}, 16'h0000);
            check("oe", {15'h0000, dataOe}, 16'h0000);
            host_u.access(16, 16'h0000, 125.0, w);
            check("first", w, `TSS_INVALID_WORD);
        end
    endtask
    // Back-to-back full reads, then a truncated one
    task t_temp_read;
        begin
            repeat (3 * CONV) @(posedge sys_clk);
            host_u.access(16, 16'h0000, 125.0, w);
            check("temp", w, 16'h0c83);
            host_u.access(16, 16'h0000, 125.0, w);
            check("again", w, 16'h0c83);
            host_u.access(5, 16'h0000, 125.0, w);
            check("short", {11'h000, w[15:11]}, 16'h0001);
            host_u.access(16, 16'h0000, 125.0, w);
            check("after", w, 16'h0c83);
        end
    endtask
    // Long select fills the buffer; result waits for deselect
    task t_fill;
        begin
            fork
                host_u.access(16, 16'h0000, 19200.0, w);
                begin
                    repeat (20) @(posedge sys_clk);
                    tempCode <= 14'h3ce0;
                    repeat (2200) @(posedge sys_clk);
                    check("full", {15'h0000, convActive}, 16'h0000);
                end
            join
            check("held", w, 16'h0c83);
            wait_conv;
            repeat (3 * CONV) @(posedge sys_clk);
            host_u.access(16, 16'h0000, 125.0, w);
            check("neg", w, 16'hf383);
        end
    endtask
    // Mode codes: last eight bits decide, applied at deselect
    task t_modes;
        begin
            host_u.access(32, 16'h00ff, 125.0, w);
            check("pre", w, 16'hf383);
            check("sd", {15'h0000, shutdownMode}, 16'h0001);
            host_u.access(16, 16'h0000, 125.0, w);
            check("ident", w, `TSS_ID_WORD);
            repeat (CONV + 50) @(posedge sys_clk);
            check("halt", {15'h0000, convActive}, 16'h0000);
            host_u.access(24, 16'h00ff, 125.0, w);
            check("cont", {15'h0000, shutdownMode}, 16'h0000);
            wait_conv;
            host_u.access(32, 16'hff00, 125.0, w);
            check("last8", {15'h0000, shutdownMode}, 16'h0000);
        end
    endtask
    initial begin
        sys_clk   = 1'b0;
        reset     = 1'b1;
        tempCode  = 14'h0320;
        err_total = 0;
        n_checks  = 0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_first_read;
        t_temp_read;
        t_fill;
        t_modes;
        test_done;
    end
endmodule
